// *** include/sst_pkg.sv ***
`default_nettype none
package sst_pkg;
  localparam logic [2:0] SST_GRP_CHA = 3'h0;
  localparam logic [2:0] SST_GRP_CHB = 3'h1;
  localparam logic [2:0] SST_GRP_SHR = 3'h2;
  localparam logic [4:0] SST_OFS_TXP = 5'h00;
  localparam logic [4:0] SST_OFS_SYNC = 5'h04;
  localparam logic [4:0] SST_OFS_RXSF = 5'h08;
  localparam logic [4:0] SST_OFS_BUF = 5'h0C;
  localparam logic [4:0] SST_OFS_MISC = 5'h10;
  localparam logic [4:0] SST_OFS_STAT = 5'h14;
  localparam logic [4:0] SST_OFS_MIC = 5'h00;
  localparam logic [4:0] SST_OFS_VEC = 5'h04;
  localparam logic [4:0] SST_OFS_VRB = 5'h08;
  localparam logic [4:0] SST_OFS_IUSC = 5'h0C;
  localparam logic [1:0] SST_CMD_RST_B = 2'h1;
  localparam logic [1:0] SST_CMD_RST_A = 2'h2;
  localparam logic [1:0] SST_CMD_HW = 2'h3;
  localparam logic [1:0] SST_LEN5 = 2'h0;
  localparam logic [1:0] SST_LEN7 = 2'h1;
  localparam logic [1:0] SST_LEN6 = 2'h2;
  localparam logic [1:0] SST_MODE_MONO = 2'h0;
  localparam logic [1:0] SST_MODE_BI = 2'h1;
  localparam logic [1:0] SST_MODE_SDLC = 2'h2;
  localparam logic [15:0] SST_POLY_CRC16 = 16'h8005;
  localparam logic [15:0] SST_POLY_CCITT = 16'h1021;
  localparam logic [15:0] SST_PRESET_SDLC = 16'hFFFF;
  localparam logic [15:0] SST_PRESET_SYNC = 16'h0000;
  localparam logic [4:0] SST_SYNC_BITS = 5'h08;
  localparam logic [4:0] SST_BISYNC_BITS = 5'h10;
  localparam logic [4:0] SST_CRC_BITS = 5'h10;
  localparam logic [7:0] SST_TXP_RST = 8'h00;
  localparam logic [7:0] SST_MISC_RST = 8'h00;

  typedef enum logic [1:0] {
    SST_SH_IDLE = 2'b00,
    SST_SH_DATA = 2'b01,
    SST_SH_CRC  = 2'b10,
    SST_SH_SYNC = 2'b11
  } sst_sh_t;

  typedef struct packed {
    logic       ready_ctl;
    logic [1:0] char_len;
    logic       brk;
    logic       tx_en;
    logic       poly_sel;
    logic       rts;
    logic       crc_en;
  } sst_txp_t;

  typedef struct packed {
    logic [1:0] cmd;
    logic       unused;
    logic       stat_high;
    logic       master_int_enable;
    logic       lower_chain_disable;
    logic       no_vector;
    logic       vector_has_status;
  } sst_mic_t;

  typedef struct packed {
    logic [1:0] sync_mode;
    logic       loop;
    logic       echo;
    logic       req_mode;
    logic       shift_left;
    logic [1:0] rsvd;
  } sst_misc_t;

  typedef struct packed {
    logic txp;
    logic sync;
    logic rxsf;
    logic buf_w;
    logic misc;
  } sst_wr_t;

  typedef struct packed {
    sst_txp_t   txp;
    logic [7:0] sync_c;
    logic [7:0] rxsf;
    sst_misc_t  misc;
    logic [7:0] buf_d;
    logic       buf_full;
    logic [2:0] txc_s;
    logic [2:0] rxs_s;
    logic [1:0] rxd_s;
    logic [15:0] sh;
    logic [4:0] cnt;
    sst_sh_t    kind;
    logic       sh_crc;
    logic [15:0] crc;
    logic       crc_sent;
    logic       loop_go;
    logic       txd;
    logic       ready_n;
    logic       rts_n;
    logic       txe;
  } sst_ch_t;

  typedef struct packed {
    sst_mic_t   mic;
    logic [7:0] vec;
    logic [7:0] ip;
    logic [7:0] under_service_bit;
    logic [2:0][7:0] src_s;
    logic [2:0] ack_s;
    logic [1:0] iei_s;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
    logic [7:0] dout;
    logic       dout_en_n;
    logic       chain_out;
    logic       int_n;
  } sst_top_t;
endpackage
`default_nettype wire

// *** rtl/sst_ctrl.sv ***
`default_nettype none

module sst_chan
  import sst_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       chan_rst,
  input  wire sst_wr_t    wr,
  input  wire logic [7:0] wdata,
  input  wire logic       txc,
  input  wire logic       rxd,
  input  wire logic       rx_sync,
  output logic            txd,
  output logic            ready_n,
  output logic            rts_n,
  output logic            txe,
  output logic [7:0]      status
);
  localparam sst_ch_t CH_RST = '{txd: 1'b1, ready_n: 1'b1, rts_n: 1'b1,
                                 crc_sent: 1'b1, kind: SST_SH_IDLE, default: '0};
  sst_ch_t q;
  sst_ch_t n;
  logic    bit_o;
  logic    go;
  logic    sync_loop;
  logic [4:0] len;
  logic [7:0] dat;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                           input logic [15:0] p);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0000);
  endfunction

  always_comb begin
    n = q;
    bit_o = 1'b1;
    len = 5'h08;
    dat = q.buf_d;
    n.txe = 1'b0;
    n.txc_s = {q.txc_s[1:0], txc};
    n.rxs_s = {q.rxs_s[1:0], rx_sync};
    n.rxd_s = {q.rxd_s[0], rxd};
    if (wr.txp) n.txp = sst_txp_t'(wdata);
    if (wr.sync) n.sync_c = wdata;
    if (wr.rxsf) n.rxsf = wdata;
    if (wr.misc) begin
      n.misc = sst_misc_t'(wdata);
      n.loop_go = 1'b0;
    end
    if (wr.buf_w) begin
      n.buf_d = wdata;
      n.buf_full = 1'b1;
    end
    sync_loop = q.misc.loop;
    // Sync found in loop: transmitter may start, break is removed
    if (sync_loop && q.rxs_s[1] && !q.rxs_s[2]) begin
      n.loop_go = 1'b1;
      n.txp.brk = 1'b0;
    end
    go = q.txp.tx_en && (!sync_loop || q.loop_go);
    case (q.txp.char_len)
      SST_LEN5: begin
        if (!q.buf_d[7]) len = 5'h05;
        else if (!q.buf_d[6]) len = 5'h04;
        else if (!q.buf_d[5]) len = 5'h03;
        else if (!q.buf_d[4]) len = 5'h02;
        else len = 5'h01;
      end
      SST_LEN7: len = 5'h07;
      SST_LEN6: len = 5'h06;
      default: len = 5'h08;
    endcase
    dat = q.buf_d & 8'((9'h001 << len[3:0]) - 9'h001);
    if (q.txc_s[2] && !q.txc_s[1]) begin
      if (q.kind == SST_SH_CRC && !q.txp.tx_en) begin
        // Dropping CRC keeps the line framed with fill instead
        n.sh = {q.rxsf, q.sync_c};
        n.cnt = SST_SYNC_BITS;
        n.kind = SST_SH_SYNC;
        n.sh_crc = 1'b0;
        if (q.misc.sync_mode == SST_MODE_SDLC) n.sh = {8'h00, q.rxsf};
        else n.sh = {8'h00, q.sync_c};
      end else if (q.cnt == 5'h00) begin
        n.sh_crc = 1'b0;
        if (!go) begin
          n.kind = SST_SH_IDLE;
        end else if (q.buf_full) begin
          n.sh = {8'h00, dat};
          n.cnt = len;
          n.kind = SST_SH_DATA;
          n.sh_crc = q.txp.crc_en;
          n.buf_full = wr.buf_w;
          n.txe = 1'b1;
          n.crc_sent = 1'b0;
          if (q.crc_sent) n.crc = (q.misc.sync_mode == SST_MODE_SDLC) ? SST_PRESET_SDLC : SST_PRESET_SYNC;
        end else if (q.txp.crc_en && !q.crc_sent) begin
          n.sh = (q.misc.sync_mode == SST_MODE_SDLC) ? ~q.crc : q.crc;
          n.cnt = SST_CRC_BITS;
          n.kind = SST_SH_CRC;
          n.crc_sent = 1'b1;
        end else begin
          n.kind = SST_SH_SYNC;
          case (q.misc.sync_mode)
            SST_MODE_SDLC: begin
              n.sh = {8'h00, q.rxsf};
              n.cnt = SST_SYNC_BITS;
            end
            SST_MODE_BI: begin
              n.sh = {q.rxsf, q.sync_c};
              n.cnt = SST_BISYNC_BITS;
            end
            default: begin
              n.sh = {8'h00, q.sync_c};
              n.cnt = SST_SYNC_BITS;
            end
          endcase
        end
      end
      if (n.cnt != 5'h00) begin
        bit_o = n.sh[0];
        if (n.sh_crc) n.crc = crc_step(n.crc, bit_o, q.txp.poly_sel ? SST_POLY_CRC16 : SST_POLY_CCITT);
        n.sh = {1'b0, n.sh[15:1]};
        n.cnt = n.cnt - 5'h01;
      end else if (q.misc.echo) begin
        bit_o = q.rxd_s[1];
      end
      if (q.txp.brk) n.txd = 1'b0;
      else if (sync_loop && !q.loop_go) n.txd = 1'b1;
      else n.txd = bit_o;
    end
    n.ready_n = n.misc.req_mode || !n.txp.ready_ctl;
    n.rts_n = !n.txp.rts;
    if (chan_rst) begin
      n.txp = sst_txp_t'(SST_TXP_RST);
      n.misc = sst_misc_t'(SST_MISC_RST);
      n.misc.shift_left = q.misc.shift_left;
      n.buf_full = 1'b0;
      n.cnt = 5'h00;
      n.kind = SST_SH_IDLE;
      n.sh_crc = 1'b0;
      n.crc_sent = 1'b1;
      n.loop_go = 1'b0;
      n.txd = 1'b1;
      n.ready_n = 1'b1;
      n.rts_n = 1'b1;
      n.txe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= CH_RST;
    else q <= n;
  end

  assign txd = q.txd;
  assign ready_n = q.ready_n;
  assign rts_n = q.rts_n;
  assign txe = q.txe;
  assign status = {q.buf_full, q.kind, q.loop_go, q.txd, q.txp.tx_en, q.txp.brk, q.crc_sent};
endmodule

module sst_ctrl
  import sst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        txc_a,
  input  wire logic        txc_b,
  input  wire logic        rxd_a,
  input  wire logic        rxd_b,
  input  wire logic        rx_sync_a,
  input  wire logic        rx_sync_b,
  output logic             txd_a,
  output logic             txd_b,
  output logic             ready_a_n,
  output logic             ready_b_n,
  output logic             rts_a_n,
  output logic             rts_b_n,
  input  wire logic [7:0]  int_src,
  input  wire logic        int_ack_n,
  input  wire logic        chain_enable_in,
  output logic             chain_enable_out,
  output logic             int_req_n,
  output logic [7:0]       host_data_lines_o,
  output logic             host_data_lines_oe_n
);
  localparam sst_top_t TOP_RST = '{dout_en_n: 1'b1, int_n: 1'b1, default: '0};
  sst_top_t   q;
  sst_top_t   n;
  sst_wr_t    wr_a;
  sst_wr_t    wr_b;
  logic       rst_a;
  logic       rst_b;
  logic       hw;
  logic       wr_en;
  logic       rd_ok;
  logic [2:0] grp;
  logic [4:0] ofs;
  logic [2:0] code;
  logic [7:0] txe_set;
  logic [7:0] clr;
  logic       txe_a;
  logic       txe_b;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  sst_mic_t   w;

  function automatic logic [2:0] top_idx(input logic [7:0] v);
    top_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) top_idx = 3'(i);
    end
  endfunction

  function automatic logic [7:0] vec_mod(input logic [7:0] v, input logic [2:0] c,
                                         input logic hi);
    vec_mod = hi ? {v[7], c[0], c[1], c[2], v[3:0]} : {v[7:4], c, v[0]};
  endfunction

  always_comb begin
    n = q;
    grp = paddr[7:5];
    ofs = paddr[4:0];
    w = sst_mic_t'(pwdata[7:0]);
    wr_en = psel && penable && q.pready && pwrite && !q.pslverr;
    wr_a = '0;
    wr_b = '0;
    hw = 1'b0;
    rst_a = 1'b0;
    rst_b = 1'b0;
    code = top_idx(q.ip);
    n.src_s = {q.src_s[1:0], int_src};
    n.ack_s = {q.ack_s[1:0], int_ack_n};
    n.iei_s = {q.iei_s[0], chain_enable_in};
    n.pready = psel && !penable;
    n.prdata = 32'h0000_0000;
    rd_ok = (paddr[1:0] == 2'h0) && ((grp == SST_GRP_SHR) ? (ofs <= SST_OFS_IUSC) :
            ((grp == SST_GRP_CHA || grp == SST_GRP_CHB) && ofs <= SST_OFS_STAT));
    n.pslverr = psel && !penable && !rd_ok;
    if (psel && !penable && rd_ok) begin
      if (grp == SST_GRP_CHA && ofs == SST_OFS_STAT) n.prdata[7:0] = stat_a;
      if (grp == SST_GRP_CHB && ofs == SST_OFS_STAT) n.prdata[7:0] = stat_b;
      if (grp == SST_GRP_SHR && ofs == SST_OFS_VEC) n.prdata[7:0] = q.vec;
      if (grp == SST_GRP_SHR && ofs == SST_OFS_VRB) n.prdata[7:0] = vec_mod(q.vec, code, q.mic.stat_high);
    end
    if (wr_en && (grp == SST_GRP_CHA || grp == SST_GRP_CHB)) begin
      wr_a.txp = (ofs == SST_OFS_TXP) && (grp == SST_GRP_CHA);
      wr_a.sync = (ofs == SST_OFS_SYNC) && (grp == SST_GRP_CHA);
      wr_a.rxsf = (ofs == SST_OFS_RXSF) && (grp == SST_GRP_CHA);
      wr_a.buf_w = (ofs == SST_OFS_BUF) && (grp == SST_GRP_CHA);
      wr_a.misc = (ofs == SST_OFS_MISC) && (grp == SST_GRP_CHA);
      wr_b.txp = (ofs == SST_OFS_TXP) && (grp == SST_GRP_CHB);
      wr_b.sync = (ofs == SST_OFS_SYNC) && (grp == SST_GRP_CHB);
      wr_b.rxsf = (ofs == SST_OFS_RXSF) && (grp == SST_GRP_CHB);
      wr_b.buf_w = (ofs == SST_OFS_BUF) && (grp == SST_GRP_CHB);
      wr_b.misc = (ofs == SST_OFS_MISC) && (grp == SST_GRP_CHB);
    end
    if (wr_en && grp == SST_GRP_SHR && ofs == SST_OFS_MIC) begin
      hw = (w.cmd == SST_CMD_HW);
      rst_a = (w.cmd == SST_CMD_RST_A) || hw;
      rst_b = (w.cmd == SST_CMD_RST_B) || hw;
      n.mic = w;
      n.mic.cmd = 2'h0;
      n.mic.unused = 1'b0;
      if (hw) begin
        n.mic.no_vector = 1'b0;
        n.mic.vector_has_status = 1'b0;
        n.under_service_bit = 8'h00;
        n.dout_en_n = 1'b1;
      end
    end
    if (wr_en && grp == SST_GRP_SHR && ofs == SST_OFS_VEC) n.vec = pwdata[7:0];
    if (wr_en && grp == SST_GRP_SHR && ofs == SST_OFS_IUSC && q.under_service_bit != 8'h00) begin
      n.under_service_bit[top_idx(q.under_service_bit)] = 1'b0;
    end
    clr = {{4{rst_a}}, {4{rst_b}}};
    n.under_service_bit = n.under_service_bit & ~clr;
    txe_set = {3'b000, txe_a, 3'b000, txe_b};
    // A new event beats a reset-command clear in the same cycle
    n.ip = (q.ip & ~clr) | txe_set | (q.src_s[1] & ~q.src_s[2]);
    if (q.ack_s[2] && !q.ack_s[1] && q.iei_s[1] && q.ip != 8'h00 && q.under_service_bit == 8'h00
        && q.mic.master_int_enable) begin
      n.under_service_bit[code] = 1'b1;
      n.ip[code] = 1'b0;
      n.dout = q.mic.vector_has_status ? vec_mod(q.vec, code, q.mic.stat_high) : q.vec;
      n.dout_en_n = q.mic.no_vector;
    end
    if (q.ack_s[1]) n.dout_en_n = 1'b1;
    if (n.mic.lower_chain_disable) n.chain_out = 1'b0;
    else if (!n.mic.master_int_enable) n.chain_out = q.iei_s[1] && (n.under_service_bit == 8'h00);
    else n.chain_out = q.iei_s[1] && (n.under_service_bit == 8'h00) && (n.ip == 8'h00);
    n.int_n = !(n.mic.master_int_enable && n.ip != 8'h00 && n.under_service_bit == 8'h00);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= TOP_RST;
    else q <= n;
  end

  sst_chan u_cha (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_rst(rst_a),
    .wr      (wr_a),
    .wdata   (pwdata[7:0]),
    .txc     (txc_a),
    .rxd     (rxd_a),
    .rx_sync (rx_sync_a),
    .txd     (txd_a),
    .ready_n (ready_a_n),
    .rts_n   (rts_a_n),
    .txe     (txe_a),
    .status  (stat_a)
  );

  sst_chan u_chb (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_rst(rst_b),
    .wr      (wr_b),
    .wdata   (pwdata[7:0]),
    .txc     (txc_b),
    .rxd     (rxd_b),
    .rx_sync (rx_sync_b),
    .txd     (txd_b),
    .ready_n (ready_b_n),
    .rts_n   (rts_b_n),
    .txe     (txe_b),
    .status  (stat_b)
  );

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign chain_enable_out = q.chain_out;
  assign int_req_n = q.int_n;
  assign host_data_lines_o = q.dout;
  assign host_data_lines_oe_n = q.dout_en_n;
endmodule
`default_nettype wire

// *** testbench/sst_ctrl_monitor.sv ***
`default_nettype none
module sst_ctrl_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txc_a,
  input wire logic        txd_a,
  input wire logic        ready_a_n,
  input wire logic        rts_a_n,
  input wire logic        chain_enable_out,
  input wire logic        host_data_lines_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wr_done;
  logic       a_rst;
  logic [7:0] txp_q;
  logic       req_q;
  logic       nv_q;
  logic [2:0] txc_q;
  logic [4:0] falls_q;
  assign wr_done = psel && penable && pready && pwrite && !pslverr;
  assign a_rst   = wr_done && paddr == 8'h40 && pwdata[7];
  // Transmit clock falls counted since the last parameter change on channel A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txp_q   <= 8'h00;
      req_q   <= 1'h0;
      nv_q    <= 1'h0;
      txc_q   <= 3'h0;
      falls_q <= 5'h00;
    end else begin
      txc_q <= {txc_q[1:0], txc_a};
      if (wr_done && paddr == 8'h00) begin
        txp_q   <= pwdata[7:0];
        falls_q <= 5'h00;
      end else if (a_rst) begin
        txp_q   <= 8'h00;
        falls_q <= 5'h00;
      end else if (txc_q[2] && !txc_q[1] && falls_q != 5'h1F) begin
        falls_q <= falls_q + 5'h01;
      end
      if (wr_done && paddr == 8'h10) begin
        req_q <= pwdata[3];
      end else if (a_rst) begin
        req_q <= 1'h0;
      end
      if (wr_done && paddr == 8'h40) begin
        nv_q <= pwdata[1] && pwdata[7:6] != 2'h3;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
    else $error("setup cycle not answered in next cycle");
  AST_MISALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("misaligned access not refused");
  AST_RST_A_MARK: assert property (a_rst |-> ##[1:4] txd_a && ready_a_n && rts_a_n)
    else $error("channel A not marking after reset command");
  AST_DLC_LOW: assert property (wr_done && paddr == 8'h40 && pwdata[2] |-> ##[1:4] !chain_enable_out)
    else $error("chain output not forced low");
  AST_NV_QUIET: assert property (nv_q && $past(nv_q) |-> host_data_lines_oe_n)
    else $error("data lines driven with no vector set");
  AST_BRK_ZERO: assert property (txp_q[4] && falls_q >= 5'h02 |-> !txd_a)
    else $error("break not sending zeros");
  AST_IDLE_MARK: assert property (txp_q[4:3] == 2'h0 && falls_q >= 5'h14 |-> txd_a)
    else $error("disabled transmitter not marking");
  AST_READY_PIN: assert property (wr_done && paddr == 8'h00 && !req_q |-> ##[1:3] ready_a_n != txp_q[7])
    else $error("modem ready pin does not follow its bit");
  COV_RST: cover property (a_rst);
  COV_BRK: cover property (txp_q[4] && falls_q >= 5'h02);
  COV_VEC: cover property (!host_data_lines_oe_n);
endmodule

bind sst_ctrl sst_ctrl_monitor i_sst_ctrl_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .txc_a(txc_a), .txd_a(txd_a),
  .ready_a_n(ready_a_n), .rts_a_n(rts_a_n), .chain_enable_out(chain_enable_out),
  .host_data_lines_oe_n(host_data_lines_oe_n)
);
`default_nettype wire

// *** testbench/sst_ctrl_tb.sv ***
`default_nettype none
module sst_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        txc_a;
  logic        rxd_a;
  logic        rx_sync_a;
  logic        txd_a;
  logic        txd_b;
  logic        ready_a_n;
  logic        ready_b_n;
  logic        rts_a_n;
  logic        rts_b_n;
  logic [7:0]  int_src;
  logic        int_ack_n;
  logic        chain_enable_in;
  logic        chain_enable_out;
  logic        int_req_n;
  logic [7:0]  host_data_lines_o;
  logic        host_data_lines_oe_n;
  logic        run;
  logic        arm;
  logic [7:0]  cap;
  logic        done;
  logic [31:0] rdat;
  logic        rerr;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [1:0]  lens [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [7:0]  bytes [4] = '{8'hE2, 8'h94, 8'hD4, 8'h14};
  logic [7:0]  caps [4] = '{8'hFE, 8'h94, 8'hD4, 8'h14};

  sst_ctrl i_sst_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .txc_a(txc_a), .txc_b(1'h0),
    .rxd_a(rxd_a), .rxd_b(1'h1), .rx_sync_a(rx_sync_a), .rx_sync_b(1'h0), .txd_a(txd_a), .txd_b(txd_b),
    .ready_a_n(ready_a_n), .ready_b_n(ready_b_n), .rts_a_n(rts_a_n), .rts_b_n(rts_b_n), .int_src(int_src),
    .int_ack_n(int_ack_n), .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
    .int_req_n(int_req_n), .host_data_lines_o(host_data_lines_o), .host_data_lines_oe_n(host_data_lines_oe_n)
  );
  sst_remote i_sst_remote (
    .run(run), .arm(arm), .txd(txd_a), .txc(txc_a), .rxd(rxd_a), .rx_sync(rx_sync_a), .cap(cap), .done(done)
  );

  task automatic give_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    apb(1'h0, a, 8'h00);
    chk(rdat, {24'h000000, d});
    chk(rerr, e);
  endtask
  task automatic raise(input int i);
    int_src <= 8'h01 << i;
    wt(8);
    int_src <= 8'h00;
    wt(4);
  endtask
  // Data lines only compared while driven
  task automatic ack(input logic [8:0] exp);
    int n;
    n = 0;
    int_ack_n <= 1'h0;
    do begin
      @(posedge pclk);
      n++;
    end while (host_data_lines_oe_n !== 1'h0 && n < 10);
    chk({host_data_lines_oe_n, host_data_lines_oe_n ? 8'h00 : host_data_lines_o}, exp);
    int_ack_n <= 1'h1;
    wt(6);
  endtask
  task automatic wdone(input logic low);
    int n;
    n = 0;
    while ((low ? txd_a !== 1'h0 : done !== 1'h1) && n < 600) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 600, 1'h1);
  endtask
  task automatic rearm;
    arm <= 1'h0;
    wt(2);
    arm <= 1'h1;
  endtask

  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    int_src = 8'h00;
    int_ack_n = 1'h1;
    chain_enable_in = 1'h1;
    run = 1'h0;
    arm = 1'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    wt(6);
    chk({txd_a, ready_a_n, rts_a_n, txd_b, ready_b_n, rts_b_n, int_req_n, host_data_lines_oe_n, chain_enable_out}, 9'h1FF);
    rd(8'h00, 8'h00, 1'h0);
    rd(8'h03, 8'h00, 1'h1);
    rd(8'h60, 8'h00, 1'h1);
    $display("test registers done");
    wr(8'h00, 8'h82);
    wr(8'h20, 8'h80);
    wr(8'h40, 8'h00);
    wt(6);
    chk({ready_a_n, rts_a_n, ready_b_n}, 3'h0);
    wr(8'h40, 8'h40);
    wt(6);
    chk({ready_a_n, rts_a_n, ready_b_n}, 3'h1);
    wr(8'h40, 8'h80);
    wt(6);
    chk({ready_a_n, rts_a_n, ready_b_n}, 3'h7);
    $display("test channel resets done");
    wr(8'h00, 8'h80);
    wr(8'h40, 8'hD4);
    wt(6);
    chk({ready_a_n, chain_enable_out}, 2'h2);
    wr(8'h40, 8'h00);
    chain_enable_in <= 1'h0;
    wt(6);
    chk(chain_enable_out, 1'h0);
    chain_enable_in <= 1'h1;
    wt(6);
    chk(chain_enable_out, 1'h1);
    wr(8'h40, 8'h84);
    wt(6);
    chk(chain_enable_out, 1'h0);
    $display("test chain control done");
    wr(8'h44, 8'h81);
    raise(6);
    wr(8'h40, 8'h00);
    rd(8'h48, 8'h8D, 1'h0);
    wr(8'h40, 8'h10);
    rd(8'h48, 8'hB1, 1'h0);
    wr(8'h40, 8'h19);
    chk(int_req_n, 1'h0);
    ack(9'h0B1);
    wr(8'h40, 8'h10);
    wt(6);
    chk(chain_enable_out, 1'h0);
    wr(8'h4C, 8'h00);
    wt(6);
    chk(chain_enable_out, 1'h1);
    wr(8'h40, 8'h1B);
    raise(4);
    ack(9'h100);
    wr(8'h4C, 8'h00);
    wr(8'h40, 8'h08);
    raise(5);
    ack(9'h081);
    wr(8'h4C, 8'h00);
    wr(8'h40, 8'h00);
    $display("test vectors done");
    wr(8'h04, 8'hFF);
    run <= 1'h1;
    rearm();
    wt(180);
    chk({done, txd_a}, 2'h1);
    for (int i = 0; i < 4; i++) begin
      rearm();
      wr(8'h00, {1'h0, lens[i], 5'h08});
      wr(8'h0C, bytes[i]);
      wdone(1'h0);
      chk(cap, caps[i]);
      wr(8'h00, 8'h00);
    end
    rearm();
    wr(8'h00, 8'h10);
    wdone(1'h0);
    chk({done, cap}, 9'h100);
    wr(8'h00, 8'h00);
    rearm();
    wr(8'h00, 8'h68);
    wr(8'h0C, 8'h00);
    wdone(1'h1);
    wr(8'h00, 8'h60);
    wdone(1'h0);
    chk({done, cap}, 9'h100);
    wr(8'h00, 8'h00);
    // Buffer filled before enabling so the data goes out ahead of any CRC
    rearm();
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h69);
    wdone(1'h0);
    wt(200);
    rd(8'h14, 8'h6D, 1'h0);
    wr(8'h00, 8'h00);
    wt(200);
    run <= 1'h0;
    $display("test transmitter done");
    give_verdict();
  end
endmodule
`default_nettype wire

// *** testbench/sst_remote.sv ***
`default_nettype none
module sst_remote (
  input  wire logic  run,
  input  wire logic  arm,
  input  wire logic  txd,
  output logic       txc,
  output logic       rxd,
  output logic       rx_sync,
  output logic [7:0] cap,
  output logic       done
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  assign rxd     = 1'h1;
  assign rx_sync = 1'h0;
  // Clock stands still while run is low so nothing moves unasked
  initial begin
    txc = 1'h0;
    forever begin
      #160;
      if (run) begin
        txc = ~txc;
      end
    end
  end
  // Capture starts at the first space so fill of ones is skipped
  always @(posedge txc or negedge arm) begin
    if (!arm) begin
      n = 0;
      done = 1'h0;
      cap = 8'h00;
    end else if (!done && (n != 0 || txd == 1'h0)) begin
      cap = {txd, cap[7:1]};
      n = n + 1;
      done = (n == 8);
    end
  end
endmodule
`default_nettype wire
